// >>> common/mct_pkg.sv
/*
 package for the multichannel timer control and channel status block.
 assumes an 8-bit register port on the system clock, one access per cycle.
//Summary of operation
//- enable low holds counter reset; high counts
//- prescale divides system clock by two^field
//- external pin clock bypasses the prescaler
//- mode 00 counts up, wraps to zero
//- mode 10 counts up then down, repeats
//- new event on set flag sets overrun
//- clearing event clears overrun; overrun read-only
//- enable low clears all event, overrun flags
//- events set flag regardless of irq enable
//- write one clears event flag; zero keeps
//- channel a bit0 through channel d bit3
//- subaddress 01h slot 0 reads overrun
//- slot 1: events at 01h, control at 00h
//- prescale write while running waits cycle end
//- any-channel bit is OR of event flags
*/
package mct_pkg;
	localparam logic [11:0] ADDR_SUBADDR = 12'h0fa4;
	localparam logic [11:0] ADDR_SLOT0 = 12'h0fa5;
	localparam logic [11:0] ADDR_SLOT1 = 12'h0fa6;
	localparam logic [11:0] ADDR_SLOT2 = 12'h0fa7;
	localparam logic [2:0] SUB_CONTROL = 3'h0;
	localparam logic [2:0] SUB_STATUS = 3'h1;
	localparam int EN_BIT = 7;
	localparam int ANY_BIT = 6;
	localparam int PRESCALE_SELECT_LSB = 3;
	localparam int PRESCALE_SELECT_MSB = 5;
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int CLKS_MSB = 2;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] MODE_MODULO = 2'h0;
	localparam logic [1:0] MODE_UPDOWN = 2'h2;
	localparam logic [2:0] CLKS_SYS = 3'h0;
	localparam logic [2:0] CLKS_GATE_HIGH = 3'h2;
	localparam logic [2:0] CLKS_GATE_LOW = 3'h3;
	localparam logic [2:0] CLKS_PIN_RISE = 3'h4;
	localparam logic [2:0] CLKS_PIN_FALL = 3'h5;
	localparam int CHANNELS = 4;
	localparam int COUNT_W = 16;

	typedef struct packed {
		logic [11:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [CHANNELS-1:0] event_flag;
		logic [CHANNELS-1:0] overrun_flag;
	} chan_status_t;
endpackage

// >>> logic/mct_prescaler.sv
/*
 power-of-two prescaler giving a one-cycle tick enable.
 assumes clear is held while the timer is stopped.
*/
`timescale 1ns/1ps
module mct_prescaler
	import mct_pkg::*;
#(
	parameter int DIV_W = 7
)
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// control
	input wire logic clear,
	input wire logic [2:0] prescale_select,
	// tick
	output logic tick
);
	logic [DIV_W-1:0] div_count;
	logic [DIV_W-1:0] mask;

	assign mask = DIV_W'((1 << prescale_select) - 1);
	assign tick = !clear && ((div_count & mask) == mask);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			div_count <= '0;
		else if (clear)
			div_count <= '0;
		else
			div_count <= div_count + DIV_W'(1);
	end
endmodule

// >>> logic/mct_ctrl_status.sv
/*
 timer enable, prescale, count modes and channel event/overrun flags
 behind the subaddress window.
 assumes channel events are one-cycle pulses on clk and the reload value
 is held by a neighbouring block.
*/
`timescale 1ns/1ps
module mct_ctrl_status
	import mct_pkg::*;
#(
	parameter int CW = COUNT_W
)
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// neighbours
	input wire logic [CW-1:0] reload_value,
	input wire logic [CHANNELS-1:0] chan_event,
	input wire logic timer_pin,
	// state
	output logic [CW-1:0] count_value,
	output logic count_end,
	output logic count_run_enable,
	output chan_status_t chan_status,
	output logic any_channel_event
);
	logic [2:0] subaddress_selector;
	logic [2:0] count_clock_source;
	logic [2:0] prescale_select;
	logic [2:0] prescale_active;
	logic [1:0] count_mode_select;
	logic count_down;
	logic [2:0] pin_sync;
	logic pin_level;
	logic pin_rise;
	logic pin_fall;
	logic presc_tick;
	logic count_tick;
	logic wr_ctrl;
	logic wr_status;
	logic [CHANNELS-1:0] clr;
	logic [CHANNELS-1:0] ev;
	logic [CHANNELS-1:0] ovr;
	logic [CW-1:0] next_count;
	logic next_down;
	logic next_end;
	logic [7:0] next_rdata;

	function automatic logic slot_hit(input reg_req_t r,
		input logic [11:0] a, input logic [2:0] sa, input logic [2:0] want);
		slot_hit = (r.addr == a) && (sa == want);
	endfunction

	assign wr_ctrl = reg_req.wr &&
		slot_hit(reg_req, ADDR_SLOT1, subaddress_selector, SUB_CONTROL);
	assign wr_status = reg_req.wr &&
		slot_hit(reg_req, ADDR_SLOT1, subaddress_selector, SUB_STATUS);
	assign clr = wr_status ? reg_req.wdata[CHANNELS-1:0] : '0;
	assign ev = chan_status.event_flag;
	assign ovr = chan_status.overrun_flag;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			subaddress_selector <= '0;
		else if (reg_req.wr && reg_req.addr == ADDR_SUBADDR)
			subaddress_selector <= reg_req.wdata[2:0];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			count_clock_source <= '0;
		else if (reg_req.wr &&
			slot_hit(reg_req, ADDR_SLOT0, subaddress_selector, SUB_CONTROL))
			count_clock_source <= reg_req.wdata[CLKS_MSB:0];
	end

	// control second register, reserved bits dropped
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			count_run_enable <= 1'b0;
			prescale_select <= '0;
			count_mode_select <= '0;
		end
		else if (wr_ctrl)
		begin
			count_run_enable <= reg_req.wdata[EN_BIT];
			prescale_select <= reg_req.wdata[PRESCALE_SELECT_MSB:PRESCALE_SELECT_LSB];
			count_mode_select <= reg_req.wdata[MODE_MSB:MODE_LSB];
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			prescale_active <= '0;
		else if (wr_ctrl && !count_run_enable)
			prescale_active <= reg_req.wdata[PRESCALE_SELECT_MSB:PRESCALE_SELECT_LSB];
		else if (!count_run_enable || count_end)
			prescale_active <= prescale_select;
	end

	// pin synchroniser and debounced level
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_sync <= '0;
			pin_level <= 1'b0;
		end
		else
		begin
			pin_sync <= {pin_sync[1:0], timer_pin};
			if (pin_sync[1] == pin_sync[2])
				pin_level <= pin_sync[2];
		end
	end

	assign pin_rise = (pin_sync[1] == pin_sync[2]) && pin_sync[2]
		&& !pin_level;
	assign pin_fall = (pin_sync[1] == pin_sync[2]) && !pin_sync[2]
		&& pin_level;

	mct_prescaler #(
		.DIV_W(7)
	) u_prescaler (
		.clk(clk),
		.nrst(nrst),
		.clear(!count_run_enable),
		.prescale_select(prescale_active),
		.tick(presc_tick)
	);

	always_comb
	begin
		case (count_clock_source)
			CLKS_SYS: count_tick = presc_tick;
			CLKS_GATE_HIGH: count_tick = presc_tick && pin_level;
			CLKS_GATE_LOW: count_tick = presc_tick && !pin_level;
			CLKS_PIN_RISE: count_tick = pin_rise;
			CLKS_PIN_FALL: count_tick = pin_fall;
			default: count_tick = presc_tick;
		endcase
	end

	// next count per mode
	always_comb
	begin
		next_count = count_value;
		next_down = count_down;
		next_end = 1'b0;
		if (count_tick)
		begin
			case (count_mode_select)
				MODE_UPDOWN:
				begin
					if (!count_down)
					begin
						if (count_value >= reload_value)
						begin
							next_down = (reload_value != '0);
							next_count = (reload_value != '0) ?
								count_value - CW'(1) : '0;
							next_end = (reload_value == '0);
						end
						else
							next_count = count_value + CW'(1);
					end
					else if (count_value <= CW'(1))
					begin
						next_count = '0;
						next_down = 1'b0;
						next_end = 1'b1;
					end
					else
						next_count = count_value - CW'(1);
				end
				default:
				begin
					next_down = 1'b0;
					if (count_value >= reload_value)
					begin
						next_count = '0;
						next_end = 1'b1;
					end
					else
						next_count = count_value + CW'(1);
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			count_value <= '0;
			count_down <= 1'b0;
			count_end <= 1'b0;
		end
		else if (!count_run_enable)
		begin
			count_value <= '0;
			count_down <= 1'b0;
			count_end <= 1'b0;
		end
		else
		begin
			count_value <= next_count;
			count_down <= next_down;
			count_end <= next_end;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			chan_status <= '0;
		else if (!count_run_enable)
			chan_status <= '0;
		else
		begin
			chan_status.event_flag <= (ev & ~clr) | chan_event;
			chan_status.overrun_flag <= (ovr & ~clr) |
				(chan_event & ev & ~clr);
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			any_channel_event <= 1'b0;
		else if (!count_run_enable)
			any_channel_event <= 1'b0;
		else
			any_channel_event <= |((ev & ~clr) | chan_event);
	end

	always_comb
	begin
		next_rdata = REG_RESET;
		if (reg_req.addr == ADDR_SUBADDR)
			next_rdata = {5'h0_0, subaddress_selector};
		else if (slot_hit(reg_req, ADDR_SLOT0, subaddress_selector,
			SUB_CONTROL))
		begin
			next_rdata[ANY_BIT] = any_channel_event;
			next_rdata[CLKS_MSB:0] = count_clock_source;
		end
		else if (slot_hit(reg_req, ADDR_SLOT0, subaddress_selector,
			SUB_STATUS))
			next_rdata[CHANNELS-1:0] = ovr;
		else if (slot_hit(reg_req, ADDR_SLOT1, subaddress_selector,
			SUB_CONTROL))
		begin
			next_rdata[EN_BIT] = count_run_enable;
			next_rdata[PRESCALE_SELECT_MSB:PRESCALE_SELECT_LSB] = prescale_select;
			next_rdata[MODE_MSB:MODE_LSB] = count_mode_select;
		end
		else if (slot_hit(reg_req, ADDR_SLOT1, subaddress_selector,
			SUB_STATUS))
			next_rdata[CHANNELS-1:0] = ev;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= REG_RESET;
		else if (reg_req.rd)
			reg_rdata <= next_rdata;
	end
endmodule

// >>> bench/mct_ctrl_status_asserts.sv
/* checker for the mct_ctrl_status ports.
 assumes one clock and an async active low reset. */
`timescale 1ns/1ps
module mct_ctrl_status_asserts
	import mct_pkg::*;
#(
	parameter int CW = COUNT_W
)
(
	// clock, reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	// neighbours
	input wire logic [CW-1:0] reload_value,
	input wire logic [CHANNELS-1:0] chan_event,
	// state
	input wire logic [CW-1:0] count_value,
	input wire logic count_end,
	input wire logic count_run_enable,
	input wire chan_status_t chan_status,
	input wire logic any_channel_event
);
	wire logic [3:0] ef = chan_status.event_flag;
	wire logic [3:0] ov = chan_status.overrun_flag;
	wire logic [3:0] hit = chan_event & ef;
	wire logic en = count_run_enable;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_any_is_or: assert property (any_channel_event == |ef)
		else $error("summary bit wrong");
	a_stop_flags: assert property (!en [*2] |-> chan_status == 8'h00)
		else $error("flags kept while stopped");
	a_stop_count: assert property (!en [*2] |-> count_value == '0)
		else $error("counter not held");
	a_event_sets: assert property (
		en && chan_event != 0 ##1 en |->
		(ef & $past(chan_event)) == $past(chan_event))
		else $error("event flag not set");
	a_ovr_sets: assert property (
		en && hit != 0 && !reg_req.wr ##1 en |->
		(ov & $past(hit)) == $past(hit))
		else $error("overrun not set");
	a_ovr_with_ev: assert property ((ov & ~ef) == 4'h0)
		else $error("overrun without event");
	a_rdata_hold: assert property (
		$changed(reg_rdata) |-> $past(reg_req.rd))
		else $error("read data moved");
	a_count_top: assert property (
		en [*2] |-> count_value <= reload_value)
		else $error("count above reload");
	c_wrap: cover property (count_end);
	c_ovr: cover property (ov != 4'h0);
	c_clear: cover property (ef != 4'h0 ##1 ef == 4'h0);
endmodule
bind mct_ctrl_status mct_ctrl_status_asserts #(.CW(CW)) chk_u (.clk, .nrst,
	.reg_req, .reg_rdata, .reload_value, .chan_event, .count_value,
	.count_end, .count_run_enable, .chan_status, .any_channel_event);

// >>> bench/mct_ctrl_status_tb_top.sv
/* bench for mct_ctrl_status, driving its ports directly.
 assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module mct_ctrl_status_tb_top
	import mct_pkg::*;
;
	typedef struct packed {
		logic [7:0] sub;
		logic [11:0] addr;
		logic [7:0] wd;
		logic [7:0] ex;
	} row_t;
	logic clk = 0;
	logic nrst = 0;
	logic timer_pin = 0;
	reg_req_t reg_req = '0;
	logic [15:0] reload_value = 16'h0003;
	logic [3:0] chan_event = 4'h0;
	logic [7:0] reg_rdata, r;
	logic [15:0] count_value;
	logic count_end, count_run_enable, any_channel_event;
	chan_status_t chan_status;
	int mismatches = 0;
	int compares = 0;
	int n;
	row_t rows [6] = '{
		'{8'h00, ADDR_SLOT1, 8'h3a, 8'h3a},
		'{8'h00, ADDR_SLOT1, 8'h92, 8'h92},
		'{8'h01, ADDR_SLOT0, 8'h0f, 8'h00},
		'{8'h01, ADDR_SLOT1, 8'h0f, 8'h00},
		'{8'h00, ADDR_SLOT2, 8'h55, 8'h00},
		'{8'h00, ADDR_SLOT1, 8'h00, 8'h00}};
	mct_ctrl_status dut_u (.clk, .nrst, .reg_req, .reg_rdata, .reload_value,
		.chan_event, .timer_pin, .count_value, .count_end,
		.count_run_enable, .chan_status, .any_channel_event);
	initial forever #20 clk = ~clk;
	task automatic test_done;
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, g, e);
		end
	endtask
	// one register access, read data left in r
	task automatic acc(input logic [11:0] a, input logic w,
		input logic [7:0] d);
		reg_req <= '{a, w, !w, d};
		@(posedge clk);
		reg_req <= '0;
		@(posedge clk);
		r = reg_rdata;
	endtask
	task automatic upto(input logic [15:0] v);
		n = 0;
		while (count_value !== v && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 400)
		begin
			mismatches++;
			test_done();
		end
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			acc(ADDR_SUBADDR, 1'b1, rows[i].sub);
			acc(rows[i].addr, 1'b1, rows[i].wd);
			acc(rows[i].addr, 1'b0, 8'h00);
			chk(16'(rows[i].ex), 16'(r));
		end
		acc(ADDR_SLOT1, 1'b1, 8'h80);
		upto(16'h0003);
		@(posedge clk);
		chk(16'h0000, count_value);
		chk(16'h0001, 16'(count_end));
		acc(ADDR_SLOT1, 1'b1, 8'h00);
		acc(ADDR_SLOT1, 1'b1, 8'h82);
		upto(16'h0003);
		@(posedge clk);
		chk(16'h0002, count_value);
		acc(ADDR_SLOT1, 1'b1, 8'h00);
		acc(ADDR_SLOT1, 1'b1, 8'h98);
		upto(16'h0001);
		upto(16'h0002);
		chk(16'h0008, 16'(n));
		acc(ADDR_SLOT1, 1'b1, 8'h80);
		upto(16'h0003);
		upto(16'h0000);
		chk(16'h0008, 16'(n));
		upto(16'h0001);
		upto(16'h0002);
		chk(16'h0001, 16'(n));
		chan_event <= 4'h5;
		@(posedge clk);
		chan_event <= 4'h0;
		acc(ADDR_SUBADDR, 1'b1, 8'h01);
		acc(ADDR_SLOT1, 1'b0, 8'h00);
		chk(16'h0005, 16'(r));
		chk(16'h0001, 16'(any_channel_event));
		chan_event <= 4'h1;
		@(posedge clk);
		chan_event <= 4'h0;
		acc(ADDR_SLOT0, 1'b0, 8'h00);
		chk(16'h0001, 16'(r));
		acc(ADDR_SLOT1, 1'b1, 8'h00);
		acc(ADDR_SLOT1, 1'b1, 8'h01);
		acc(ADDR_SLOT1, 1'b0, 8'h00);
		chk(16'h0004, 16'(r));
		acc(ADDR_SLOT0, 1'b0, 8'h00);
		chk(16'h0000, 16'(r));
		acc(ADDR_SUBADDR, 1'b1, 8'h00);
		acc(ADDR_SLOT1, 1'b1, 8'h00);
		@(posedge clk);
		chk(16'h0000, 16'(chan_status));
		chk(16'h0000, count_value);
		reload_value <= 16'h0064;
		acc(ADDR_SLOT0, 1'b1, 8'h04);
		acc(ADDR_SLOT1, 1'b1, 8'h80);
		repeat (3)
		begin
			timer_pin <= 1'b1;
			repeat (4) @(posedge clk);
			timer_pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
		chk(16'h0003, count_value);
		nrst <= 1'b0;
		@(posedge clk);
		chk(16'h0000, 16'(count_run_enable));
		nrst <= 1'b1;
		acc(ADDR_SLOT1, 1'b0, 8'h00);
		chk(16'h0000, 16'(r));
		test_done();
	end
endmodule
